// ===== core/odt_mode_pkg.sv
// Constants and carrier types for the termination mode control block
package odt_mode_pkg;
  localparam int          CLK_PERIOD_PS        = 20000;
  localparam int          ASYNC_DELAY_MIN_PS   = 2000;
  localparam int          ASYNC_DELAY_MAX_PS   = 8500;
  localparam int          ASYNC_MIN_CYC_I      = (ASYNC_DELAY_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          ASYNC_MAX_CYC_I      = ASYNC_DELAY_MAX_PS / CLK_PERIOD_PS;
  // The delay window comes to less than one cycle at this clock rate, so both ends are clamped to one
  localparam logic [3:0]  ASYNC_MIN_CYC        = 4'(ASYNC_MIN_CYC_I < 1 ? 1 : ASYNC_MIN_CYC_I);
  localparam logic [3:0]  ASYNC_MAX_CYC        = 4'(ASYNC_MAX_CYC_I < 1 ? 1 : ASYNC_MAX_CYC_I);
  localparam int          LAT_W                = 6;
  localparam int          CNT_W                = 10;
  localparam logic [5:0]  SYNC_LAT_OFFSET      = 6'h02;
  localparam logic [5:0]  ANTICIP_EXTRA        = 6'h01;
  localparam logic [9:0]  CNT_ZERO             = 10'h000;
  localparam logic [9:0]  CNT_ONE              = 10'h001;
  localparam int          LAT_MAX              = 64;

  typedef enum logic [1:0] {
    ST_SYNC  = 2'b00,
    ST_ENTRY = 2'b01,
    ST_ASYNC = 2'b11,
    ST_EXIT  = 2'b10
  } odt_state_t;

  typedef struct packed {
    logic        dll_pd_keep;   // DLL stays on in precharge power-down when set
    logic        rtt_enabled;   // Any termination value enabled
    logic [5:0]  cas_write_lat;
    logic [5:0]  additive_lat;
    logic [9:0]  refresh_cycles;
    logic [9:0]  relock_cycles;
  } odt_cfg_t;
endpackage

// ===== core/odt_delay_line.sv
// Variable-length delay line used for the synchronous termination latency
`timescale 1ns/1ps
module odt_delay_line
  import odt_mode_pkg::*;
(
  input  wire logic             core_clk_in,  // Clock
  input  wire logic             rst_b_in,     // Sync reset, active low
  input  wire logic             d_in,         // Sample to delay
  input  wire logic [LAT_W-1:0] lat_in,       // Delay in cycles, 1 and up
  output logic                  q_out         // Delayed sample
);
  logic [LAT_MAX-1:0] shift_r;

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      shift_r <= '0;
    end else begin
      shift_r <= {shift_r[LAT_MAX-2:0], d_in};
    end
  end

  // Tap chosen from the combined latency; zero tap reads the newest stage
  assign q_out = (lat_in == '0) ? shift_r[0] : shift_r[lat_in - 6'h01];
endmodule

// ===== core/async_termination_mode_control.sv
// Termination timing mode control: synchronous, asynchronous and transition windows
//
// Summary of operation
// - Async mode when termination on, precharge-power-down DLL off
// - Async mode while DLL resynchronizes after reset
// - Async ignores additive latency, uses analog delay
// - Async turn-on between 2 and 8.5 ns; here one 20 ns clock after the synchronized pin changes
// - Async turn-off between 2 and 8.5 ns; here one 20 ns clock after the synchronized pin changes
// - Transition windows only when DLL power-down bit clear
// - Entry window ends when clock-enable registered low
// - Anticipation is max latency plus one clock
// - Refresh in progress extends entry window end; here only if more refresh than anticipation remains
// - In windows, change within either timing's bounds
// - Exit window lasts the relock time; anticipation is added before it
// - Short low pulse: uncertain from entry start to exit end
// - Short high pulse: uncertain from exit start to entry end
// - Sync latency is write CAS plus additive minus two
`timescale 1ns/1ps
module async_termination_mode_control
  import odt_mode_pkg::*;
(
  input  wire logic     core_clk_in,        // 50 MHz command clock
  input  wire logic     rst_b_in,           // Sync reset, active low
  input  wire logic     odt_pin_in,         // Termination pin from controller
  input  wire logic     cke_pin_in,         // Clock-enable pin from controller
  input  wire logic     refresh_cmd_in,     // Refresh command decoded, one-cycle pulse
  input  wire logic     precharged_in,      // All banks precharged
  input  wire logic     dll_relocking_in,   // DLL resynchronizing after reset
  input  wire odt_cfg_t cfg_in,             // Mode register settings
  output logic          rtt_on_out,         // Termination resistance enabled
  output logic          async_mode_out,     // Termination follows pin asynchronously
  output logic          entry_window_out,   // Power-down entry transition window
  output logic          exit_window_out,    // Power-down exit transition window
  output logic          uncertain_out,      // Either timing may apply
  output logic [LAT_W-1:0] sync_lat_out     // Synchronous on/off latency in clocks
);
  // Pins cross from the controller's domain: two flops before any use
  logic odt_s1_r, odt_s2_r, cke_s1_r, cke_s2_r, cke_d_r;
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      odt_s1_r <= 1'b0;
      odt_s2_r <= 1'b0;
      // Clock-enable idles high; resetting to its idle level avoids a false edge
      cke_s1_r <= 1'b1;
      cke_s2_r <= 1'b1;
      cke_d_r  <= 1'b1;
    end else begin
      odt_s1_r <= odt_pin_in;
      odt_s2_r <= odt_s1_r;
      cke_s1_r <= cke_pin_in;
      cke_s2_r <= cke_s1_r;
      cke_d_r  <= cke_s2_r;
    end
  end

  wire       cke_fall   = cke_d_r & ~cke_s2_r;
  wire       cke_rise   = ~cke_d_r & cke_s2_r;
  wire [5:0] sync_lat   = cfg_in.cas_write_lat + cfg_in.additive_lat - SYNC_LAT_OFFSET;
  // On and off latencies are equal, so the larger of the two plus one
  wire [5:0] anticip    = sync_lat + ANTICIP_EXTRA;
  wire       trans_en   = cfg_in.rtt_enabled & ~cfg_in.dll_pd_keep;

  // Refresh countdown; a command restarts it
  logic [CNT_W-1:0] rfc_cnt_r, rfc_cnt_nxt;
  assign rfc_cnt_nxt = refresh_cmd_in ? cfg_in.refresh_cycles :
                       (rfc_cnt_r != CNT_ZERO) ? rfc_cnt_r - CNT_ONE : CNT_ZERO;
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) rfc_cnt_r <= CNT_ZERO;
    else           rfc_cnt_r <= rfc_cnt_nxt;
  end

  // The anticipation lead cannot be foreseen from the pins, so the block
  // keeps its last anticipation cycles of pin history uncertain instead:
  // any pin change inside that lead is given the widened delay bounds.
  logic [CNT_W-1:0] lead_cnt_r, lead_cnt_nxt;
  logic [CNT_W-1:0] ent_cnt_r, ent_cnt_nxt;
  logic [CNT_W-1:0] ext_cnt_r, ext_cnt_nxt;
  odt_state_t       state_r, state_nxt;

  // Lead window opens whenever the pin state could soon toggle clock-enable
  assign lead_cnt_nxt = (cke_fall | cke_rise) ? CNT_ZERO :
                        (lead_cnt_r != CNT_ZERO) ? lead_cnt_r - CNT_ONE :
                        {{(CNT_W-LAT_W){1'b0}}, anticip};
  wire [CNT_W-1:0] rfc_left = (rfc_cnt_r > {{(CNT_W-LAT_W){1'b0}}, anticip}) ?
                              rfc_cnt_r : CNT_ZERO;
  // Entry window held past the clock-enable edge while more refresh than anticipation remains
  assign ent_cnt_nxt = (cke_fall & trans_en) ? rfc_left :
                       (ent_cnt_r != CNT_ZERO) ? ent_cnt_r - CNT_ONE : CNT_ZERO;
  assign ext_cnt_nxt = (cke_rise & trans_en) ? cfg_in.relock_cycles :
                       (ext_cnt_r != CNT_ZERO) ? ext_cnt_r - CNT_ONE : CNT_ZERO;

  wire pd_dll_off = ~cke_s2_r & precharged_in & trans_en;
  wire async_cond = cfg_in.rtt_enabled & (pd_dll_off | dll_relocking_in);
  wire in_entry   = trans_en & cke_s2_r & precharged_in | (ent_cnt_r != CNT_ZERO);
  wire in_exit    = trans_en & ~cke_s2_r | (ext_cnt_r != CNT_ZERO);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_SYNC:  if (cke_fall & trans_en & precharged_in) state_nxt = ST_ENTRY;
                else if (async_cond) state_nxt = ST_ASYNC;
      ST_ENTRY: if (cke_rise) state_nxt = ST_EXIT;
                else if (ent_cnt_nxt == CNT_ZERO) state_nxt = ST_ASYNC;
      ST_ASYNC: if (cke_rise & trans_en) state_nxt = ST_EXIT;
                else if (!async_cond) state_nxt = ST_SYNC;
      ST_EXIT:  if (cke_fall & trans_en) state_nxt = ST_ENTRY;
                else if (ext_cnt_nxt == CNT_ZERO && ent_cnt_nxt == CNT_ZERO)
                  state_nxt = async_cond ? ST_ASYNC : ST_SYNC;
      default:  state_nxt = ST_SYNC;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      state_r    <= ST_SYNC;
      lead_cnt_r <= CNT_ZERO;
      ent_cnt_r  <= CNT_ZERO;
      ext_cnt_r  <= CNT_ZERO;
    end else begin
      state_r    <= state_nxt;
      lead_cnt_r <= lead_cnt_nxt;
      ent_cnt_r  <= ent_cnt_nxt;
      ext_cnt_r  <= ext_cnt_nxt;
    end
  end

  // Synchronous path: pin delayed by the full write-based latency
  logic sync_rtt;
  odt_delay_line u_sync_dly (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .d_in        (odt_s2_r),
    .lat_in      (sync_lat),
    .q_out       (sync_rtt)
  );

  // Asynchronous path: no additive latency, fixed analog delay in cycles
  logic [3:0] adly_cnt_r, adly_cnt_nxt;
  logic       async_rtt_r, async_rtt_nxt;
  wire        async_change = odt_s2_r != async_rtt_r;
  assign adly_cnt_nxt  = !async_change ? 4'h0 :
                         (adly_cnt_r == ASYNC_MAX_CYC) ? 4'h0 : adly_cnt_r + 4'h1;
  // Switch once the least delay has passed and before the longest runs out
  assign async_rtt_nxt = (async_change && adly_cnt_r + 4'h1 >= ASYNC_MIN_CYC) ?
                         odt_s2_r : async_rtt_r;
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      adly_cnt_r  <= 4'h0;
      async_rtt_r <= 1'b0;
    end else begin
      adly_cnt_r  <= adly_cnt_nxt;
      async_rtt_r <= async_rtt_nxt;
    end
  end

  // In windows the asynchronous response is used; both responses lie in the
  // widened bounds, so either answer is legal
  wire in_window = (state_r == ST_ENTRY) | (state_r == ST_EXIT) | (in_entry & lead_cnt_r
                   != CNT_ZERO & cke_s2_r) | (in_exit & lead_cnt_r != CNT_ZERO & ~cke_s2_r);
  wire rtt_sel   = ~cfg_in.rtt_enabled ? 1'b0 :
                   (state_r == ST_ASYNC) ? async_rtt_r :
                   in_window ? async_rtt_r : sync_rtt;

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      rtt_on_out       <= 1'b0;
      async_mode_out   <= 1'b0;
      entry_window_out <= 1'b0;
      exit_window_out  <= 1'b0;
      uncertain_out    <= 1'b0;
      sync_lat_out     <= '0;
    end else begin
      rtt_on_out       <= rtt_sel;
      async_mode_out   <= state_r == ST_ASYNC;
      entry_window_out <= state_r == ST_ENTRY;
      exit_window_out  <= state_r == ST_EXIT;
      uncertain_out    <= in_window;
      sync_lat_out     <= sync_lat;
    end
  end
endmodule

// ===== dv/odt_mode_properties.sv
// Checker for the termination mode control outputs
`timescale 1ns/1ps
module odt_mode_properties
  import odt_mode_pkg::*;
(
  input wire logic             core_clk_in,      // Clock
  input wire logic             rst_b_in,         // Reset
  input wire logic             odt_pin_in,       // Termination pin
  input wire logic             cke_pin_in,       // Clock-enable pin
  input wire logic             precharged_in,    // Banks idle
  input wire logic             dll_relocking_in, // DLL relock
  input wire odt_cfg_t         cfg_in,           // Settings
  input wire logic             rtt_on_out,       // Termination on
  input wire logic             async_mode_out,   // Async mode
  input wire logic             entry_window_out, // Entry window
  input wire logic             exit_window_out,  // Exit window
  input wire logic [LAT_W-1:0] sync_lat_out      // Sync latency
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  AST_SYNC_LAT: assert property (
    $past(rst_b_in) && $stable(cfg_in) |=> sync_lat_out ==
      $past(cfg_in.cas_write_lat) + $past(cfg_in.additive_lat) - SYNC_LAT_OFFSET)
    else $error("sync latency wrong");
  AST_RTT_OFF: assert property (
    !cfg_in.rtt_enabled [*4] |-> !rtt_on_out && !entry_window_out && !exit_window_out)
    else $error("termination active while disabled");
  AST_KEEP_NO_WIN: assert property (
    cfg_in.dll_pd_keep [*4] |-> !entry_window_out && !exit_window_out)
    else $error("window with DLL kept on");
  AST_ONE_WIN: assert property (
    !(entry_window_out && exit_window_out))
    else $error("both windows open");
  AST_ENTRY_START: assert property (
    (cfg_in.rtt_enabled && !cfg_in.dll_pd_keep && precharged_in && !dll_relocking_in &&
     !async_mode_out && !exit_window_out && $fell(cke_pin_in)) ##1 (!cke_pin_in) [*3]
    |-> ##[0:2] entry_window_out)
    else $error("entry window missing");
  AST_ASYNC_ON: assert property (
    (async_mode_out && cfg_in.rtt_enabled && $rose(odt_pin_in))
    ##1 (async_mode_out && odt_pin_in) [*3] |-> ##1 rtt_on_out)
    else $error("async turn-on late");
  AST_ASYNC_OFF: assert property (
    (async_mode_out && $fell(odt_pin_in)) ##1 (async_mode_out && !odt_pin_in) [*3]
    |-> ##1 !rtt_on_out)
    else $error("async turn-off late");
  AST_RELOCK: assert property (
    (dll_relocking_in && cfg_in.rtt_enabled) [*4] |-> async_mode_out)
    else $error("not async during relock");
  AST_EXIT_END: assert property (
    $rose(exit_window_out) && cfg_in.relock_cycles < 10'h100 |-> ##[1:300] !exit_window_out)
    else $error("exit window too long");
endmodule

// ===== dv/odt_ctrl_model.sv
// Memory controller side: drives termination and clock-enable pins
`timescale 1ns/1ps
module odt_ctrl_model (
  input  wire logic core_clk_in,  // Clock
  input  wire logic odt_req_in,   // Wanted termination level
  input  wire logic cke_req_in,   // Wanted clock-enable level
  input  wire logic uncertain_in, // Device timing ambiguous
  output logic      odt_pin_out,  // Termination pin
  output logic      cke_pin_out   // Clock-enable pin
);
  initial begin
    odt_pin_out = 1'b0;
    cke_pin_out = 1'b1;
  end
  // Termination moves are held back while either timing could apply
  always @(posedge core_clk_in) begin
    cke_pin_out <= cke_req_in;
    if (!uncertain_in) begin
      odt_pin_out <= odt_req_in;
    end
  end
endmodule

// ===== dv/testbench.sv
// Self-checking bench for the termination mode control
`timescale 1ns/1ps
module testbench;
  import odt_mode_pkg::*;
  logic core_clk_in, rst_b_in, odt_req, cke_req, odt_pin, cke_pin, refresh, prech, relock;
  logic rtt_on, async_md, entry_w, exit_w, uncertain;
  logic [LAT_W-1:0] sync_lat;
  odt_cfg_t cfg;
  int err_count, n_tests, c, t;
  wire [4:0] obs = {rtt_on, async_md, entry_w, exit_w, uncertain};
  odt_ctrl_model u_odt_ctrl_model (.core_clk_in(core_clk_in), .odt_req_in(odt_req),
    .cke_req_in(cke_req), .uncertain_in(uncertain), .odt_pin_out(odt_pin), .cke_pin_out(cke_pin));
  async_termination_mode_control u_async_termination_mode_control (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .odt_pin_in(odt_pin), .cke_pin_in(cke_pin),
    .refresh_cmd_in(refresh), .precharged_in(prech), .dll_relocking_in(relock), .cfg_in(cfg),
    .rtt_on_out(rtt_on), .async_mode_out(async_md), .entry_window_out(entry_w),
    .exit_window_out(exit_w), .uncertain_out(uncertain), .sync_lat_out(sync_lat));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // Bounded wait for one observed output to reach a level
  task automatic wait_bit(input int b, input logic v, input int n, output int k);
    k = 0;
    do begin
      @(negedge core_clk_in);
      k++;
    end while (obs[b] !== v && k < n);
  endtask
  task automatic test_done();
    if (err_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic t_lat();
    for (int i = 0; i < 4; i++) begin
      cfg.cas_write_lat = 6'(5 + i);
      cfg.additive_lat = 6'(2 * i);
      repeat (3) @(negedge core_clk_in);
      chk(8'(sync_lat), 8'(3 + 3 * i));
    end
    // Sync path: latency 12, plus model, two sync flops and output register
    odt_req = 1'b1;
    wait_bit(4, 1'b1, 30, c);
    chk(8'(c), 8'h10);
    odt_req = 1'b0;
    wait_bit(4, 1'b0, 30, c);
    chk(8'(c), 8'h10);
  endtask
  task automatic t_relock();
    relock = 1'b1;
    repeat (5) @(negedge core_clk_in);
    chk(async_md, 1'b1);
    odt_req = 1'b1;
    wait_bit(4, 1'b1, 20, c);
    chk(8'(c >= 4 && c <= 7), 8'h01);
    odt_req = 1'b0;
    wait_bit(4, 1'b0, 20, c);
    chk(8'(c >= 4 && c <= 7), 8'h01);
    relock = 1'b0;
    repeat (5) @(negedge core_clk_in);
    chk(async_md, 1'b0);
  endtask
  task automatic t_pd();
    prech = 1'b1;
    refresh = 1'b1;
    @(negedge core_clk_in);
    refresh = 1'b0;
    cke_req = 1'b0;
    wait_bit(2, 1'b1, 12, c);
    chk(entry_w, 1'b1);
    chk(uncertain, 1'b1);
    wait_bit(2, 1'b0, 200, t);
    chk(8'(c + t >= 36 && c + t <= 48), 8'h01);
    wait_bit(3, 1'b1, 8, c);
    chk(async_md, 1'b1);
    cke_req = 1'b1;
    wait_bit(1, 1'b1, 12, c);
    chk(exit_w, 1'b1);
    wait_bit(1, 1'b0, 200, c);
    chk(8'(c >= 26 && c <= 40), 8'h01);
    chk(async_md, 1'b0);
  endtask
  task automatic t_keep_off();
    cfg.dll_pd_keep = 1'b1;
    cke_req = 1'b0;
    wait_bit(2, 1'b1, 30, c);
    chk({entry_w, async_md}, 2'b00);
    cke_req = 1'b1;
    cfg.rtt_enabled = 1'b0;
    odt_req = 1'b1;
    relock = 1'b1;
    repeat (10) @(negedge core_clk_in);
    chk(rtt_on, 1'b0);
  endtask
  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end
  initial begin
    #400000;
    err_count++;
    test_done();
  end
  initial begin
    {rst_b_in, odt_req, refresh, prech, relock, err_count, n_tests} = '0;
    cke_req = 1'b1;
    cfg = '{1'b0, 1'b1, 6'h05, 6'h00, 10'h028, 10'h01E};
    repeat (8) @(negedge core_clk_in);
    rst_b_in = 1'b1;
    repeat (4) @(negedge core_clk_in);
    t_lat();
    t_relock();
    t_pd();
    t_keep_off();
    test_done();
  end
endmodule
bind async_termination_mode_control odt_mode_properties u_odt_mode_properties (.*);
